// File: src/mpd_parser.sv
`timescale 1ns/1ps
module mpd_parser import mpd_pkg::*; (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  // Handler state and results.
  input wire logic handler_busy_i,
  output logic [3:0] line_override_o,
  output logic illegal_o,
  output logic done_o
);

  typedef struct packed {
    mpd_st_e st;
    logic [6:0] cnt;
    logic is_cfg;
    logic seen_lcd;
    logic seen_cfg;
    logic err;
    logic done;
    logic ack;
    logic [31:0] rdat;
    logic [6:0] daddr;
    logic [5:0] vaddr;
    logic [3:0] ovr;
    logic [1:0] sel;
    logic [3:0] lwr;
    logic [3:0][19:0][7:0] disp;
    logic [3:0][19:0][7:0] lstg;
    logic [39:0][7:0] cstg;
    logic [3:0][15:0][7:0] val;
  } mpd_state_s;

  mpd_state_s q, d;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  function automatic logic [7:0] txt_chr(input logic [159:0] t, input logic [4:0] p);
    logic [7:0] c;
    c = t[159 - 8 * int'(p) -: 8];
    return (c == 8'h00) ? BLANK : c;
  endfunction

  // Exact, zero-terminated compare; a 20-character name must end at byte 24.
  function automatic logic name_hit(input logic [39:0][7:0] c, input logic [159:0] nm);
    logic ended;
    logic hit;
    ended = 1'b0;
    hit = 1'b1;
    for (int i = 0; i < LINE_CH; i++) begin
      if (!ended && c[NAME_IX + i] != nm[159 - 8 * i -: 8]) begin
        hit = 1'b0;
      end
      if (c[NAME_IX + i] == 8'h00) begin
        ended = 1'b1;
      end
    end
    if (!ended && c[NAME_END_IX] != 8'h00) begin
      hit = 1'b0;
    end
    return hit;
  endfunction

  function automatic logic [1:0] line_of(input logic [6:0] k);
    if (k >= 7'h3C) begin
      return 2'h3;
    end else if (k >= 7'h28) begin
      return 2'h2;
    end else if (k >= 7'h14) begin
      return 2'h1;
    end
    return 2'h0;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state.

  logic wr_req;
  logic [7:0] byt;
  logic [6:0] k;
  logic [1:0] ln;
  logic [4:0] ps;
  logic [1:0] ty;
  logic [4:0] len;
  logic alter;
  logic term;
  logic hit;
  logic [1:0] hix;
  logic ok;
  logic zed;
  logic [15:0][7:0] nv;

  always_comb begin
    d = q;
    wr_req = wb_cyc_i && wb_stb_i && wb_we_i && !q.ack && wb_sel_i[0];
    byt = wb_dat_i[7:0];
    k = q.cnt - LCD_TEXT0;
    ln = line_of(k);
    ps = 5'(k - 7'(ln) * 7'd20);
    ty = q.cstg[0][6:5];
    len = q.cstg[0][4:0];
    alter = q.cstg[0][7];
    term = 1'b0;
    hit = 1'b0;
    hix = 2'h0;
    ok = 1'b1;
    zed = 1'b0;
    nv = '0;

    // Classic Wishbone: one wait state, ack drops the cycle after it rises.
    d.ack = wb_cyc_i && wb_stb_i && !q.ack;
    d.rdat = 32'h0;
    case (wb_adr_i)
      ADR_STAT: d.rdat = {29'h0, q.err, q.done, q.st != ST_IDLE};
      ADR_OVR: d.rdat = {28'h0, q.ovr};
      ADR_SEL: d.rdat = {30'h0, q.sel};
      ADR_DADR: d.rdat = {25'h0, q.daddr};
      ADR_VADR: d.rdat = {26'h0, q.vaddr};
      ADR_DDAT: begin
        if (q.ovr[q.daddr[6:5]]) begin
          d.rdat = {24'h0, q.disp[q.daddr[6:5]][q.daddr[4:0]]};
        end else begin
          case (q.daddr[6:5])
            2'h0: d.rdat = {24'h0, txt_chr(MODEL_TXT, q.daddr[4:0])};
            2'h2: d.rdat = {24'h0, txt_chr(handler_busy_i ? BUSY_TXT : IDLE_TXT,
                                           q.daddr[4:0])};
            default: d.rdat = {24'h0, BLANK};
          endcase
        end
      end
      // Values are stored first byte at the top index, so byte 0 reads the top.
      ADR_VDAT: d.rdat = {24'h0, q.val[q.vaddr[5:4]][4'hF - q.vaddr[3:0]]};
      default: d.rdat = 32'h0;
    endcase

    // Terminator search and name lookup for the staged configuration page.
    for (int i = VAL_IX; i < CFG_BYTES; i++) begin
      if (q.cstg[i] == 8'h00) begin
        term = 1'b1;
      end
    end
    for (int v = NVAR - 1; v >= 0; v--) begin
      if (name_hit(q.cstg, VAR_NAME[v])) begin
        hit = 1'b1;
        hix = 2'(v);
      end
    end

    if (wr_req && wb_adr_i == ADR_DADR) begin
      d.daddr = wb_dat_i[6:0];
    end
    if (wr_req && wb_adr_i == ADR_VADR) begin
      d.vaddr = wb_dat_i[5:0];
    end

    if (wr_req && wb_adr_i == ADR_DATA) begin
      case (q.st)
        ST_HDR: begin
          d.cnt = q.cnt + 7'h01;
          if (q.cnt == HDR_LAST) begin
            d.st = ST_CODE;
          end
        end
        ST_CODE: begin
          d.st = ST_LEN;
          if (byt == LCD_CODE && !q.seen_lcd) begin
            d.is_cfg = 1'b0;
            d.seen_lcd = 1'b1;
          end else if (byt == CFG_CODE && !q.seen_cfg) begin
            d.is_cfg = 1'b1;
            d.seen_cfg = 1'b1;
          end else begin
            d.err = 1'b1;
            d.st = ST_IDLE;
          end
        end
        ST_LEN: begin
          d.cnt = BODY_FIRST;
          d.st = ST_BODY;
          if (byt != (q.is_cfg ? CFG_LEN : LCD_LEN)) begin
            d.err = 1'b1;
            d.st = ST_IDLE;
          end
        end
        ST_BODY: begin
          d.cnt = q.cnt + 7'h01;
          if (q.is_cfg) begin
            d.cstg[6'(q.cnt - BODY_FIRST)] = byt;
            if (q.cnt == CFG_LAST) begin
              d.st = ST_CODE;
            end
          end else begin
            if (q.cnt == BODY_FIRST) begin
              d.lwr = {byt[0], byt[1], byt[2], byt[3]};
            end else if (q.cnt >= LCD_TEXT0) begin
              d.lstg[ln][ps] = byt;
            end
            if (q.cnt == LCD_LAST) begin
              d.st = ST_CODE;
            end
          end
        end
        default: d.st = q.st;
      endcase
    end

    if (wr_req && wb_adr_i == ADR_CTRL && wb_dat_i[CTRL_START]) begin
      d.st = ST_HDR;
      d.cnt = 7'h00;
      d.err = 1'b0;
      d.done = 1'b0;
      d.seen_lcd = 1'b0;
      d.seen_cfg = 1'b0;
    end else if (wr_req && wb_adr_i == ADR_CTRL && wb_dat_i[CTRL_FINISH] && q.st != ST_IDLE) begin
      d.st = ST_IDLE;
      d.done = 1'b1;
      // A list cut off inside a page is malformed.
      ok = !q.err && q.st == ST_CODE;
      if (q.seen_cfg) begin
        if (alter) begin
          ok = ok && hit && VAR_WR[hix] && ty == VAR_TYPE[hix];
          if (ty == TY_ASCII) begin
            ok = ok && len <= 5'd16 && (len != 5'h00 || term);
          end else begin
            ok = ok && len == VAR_LEN[hix];
          end
        end else if (q.cstg[NAME_IX] != 8'h00) begin
          ok = ok && hit;
        end
      end
      for (int v = 0; v < VAL_MAX; v++) begin
        if (q.cstg[VAL_IX + v] == 8'h00) begin
          zed = 1'b1;
        end
        // Bytes past the length or terminator are cleared, so stored values stay canonical.
        if (ty == TY_ASCII && len == 5'h00) begin
          nv[v] = zed ? 8'h00 : q.cstg[VAL_IX + v];
        end else begin
          nv[v] = (5'(v) < len) ? q.cstg[VAL_IX + v] : 8'h00;
        end
      end
      if (!ok) begin
        d.err = 1'b1;
      end else begin
        if (q.seen_lcd) begin
          d.ovr = q.lwr;
          for (int l = 0; l < LINES; l++) begin
            zed = 1'b0;
            for (int p = 0; p < LINE_CH; p++) begin
              if (q.lstg[l][p] == 8'h00) begin
                zed = 1'b1;
              end
              d.disp[l][p] = zed ? BLANK : q.lstg[l][p];
            end
          end
        end
        if (q.seen_cfg) begin
          d.sel = (q.cstg[NAME_IX] == 8'h00 && !alter) ? 2'h0 : hix;
          if (alter) begin
            for (int v = 0; v < VAL_MAX; v++) begin
              d.val[hix][v] = nv[VAL_MAX - 1 - v];
            end
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.val <= VAL_RST;
    end else begin
      q <= d;
    end
  end

  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.rdat;
  assign line_override_o = q.ovr;
  assign illegal_o = q.err;
  assign done_o = q.done;

endmodule // mpd_parser

// File: src/mpd_pkg.sv
// Contract
// - Display page code byte is 22 hex.
// - Display page length byte must be 52 hex.
// - Per-line bit: 0 internal text, 1 host.
// - Host lines sit at bytes 4-23 to 64-83.
// - Internal text: model line one, status line three.
// - Internal line two stays blank.
// - Configuration page code byte is 3D hex.
// - Configuration page length byte must be 28 hex.
// - Alter flag set updates, else only selects.
// - Alter needs type, length, name, alterable all good.
// - Type codes: ASCII, bytes, signed, unsigned.
// - Supplied type must equal variable type.
// - ASCII length zero means zero-terminated, max 16.
// - Byte array length is its size, max 16.
// - Integers are 1, 2 or 4 bytes, MSB first.
// - Name is bytes 4-23, zero-terminated, 20 max.
// - Alter needs an exact name match.
// - Empty name in select picks first variable.
// - Pages in any order, each at most once.
// - Value bytes ignored unless alter flag set.
package mpd_pkg;

  // Register byte addresses.
  localparam logic [5:0] ADR_CTRL = 6'h00;
  localparam logic [5:0] ADR_DATA = 6'h04;
  localparam logic [5:0] ADR_STAT = 6'h08;
  localparam logic [5:0] ADR_OVR = 6'h0C;
  localparam logic [5:0] ADR_SEL = 6'h10;
  localparam logic [5:0] ADR_DADR = 6'h14;
  localparam logic [5:0] ADR_DDAT = 6'h18;
  localparam logic [5:0] ADR_VADR = 6'h1C;
  localparam logic [5:0] ADR_VDAT = 6'h20;
  localparam int CTRL_START = 0;
  localparam int CTRL_FINISH = 1;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_ILL = 2;

  // Page layout.
  localparam logic [7:0] LCD_CODE = 8'h22;
  localparam logic [7:0] LCD_LEN = 8'h52;
  localparam logic [7:0] CFG_CODE = 8'h3D;
  localparam logic [7:0] CFG_LEN = 8'h28;
  localparam logic [6:0] HDR_LAST = 7'h03;
  localparam logic [6:0] BODY_FIRST = 7'h02;
  localparam logic [6:0] LCD_TEXT0 = 7'h04;
  localparam logic [6:0] LCD_LAST = 7'h53;
  localparam logic [6:0] CFG_LAST = 7'h29;
  localparam int LINES = 4;
  localparam int LINE_CH = 20;
  localparam int CFG_BYTES = 40;
  localparam int NAME_IX = 2;
  localparam int NAME_END_IX = 22;
  localparam int VAL_IX = 23;
  localparam int VAL_MAX = 16;
  localparam logic [7:0] BLANK = 8'h20;

  // Type codes.
  localparam logic [1:0] TY_ASCII = 2'h0;
  localparam logic [1:0] TY_BYTES = 2'h1;
  localparam logic [1:0] TY_SIGNED = 2'h2;
  localparam logic [1:0] TY_UNSIGNED = 2'h3;

  // Internal display text.
  localparam logic [159:0] MODEL_TXT = {"LIBRARY MODEL 01", 32'h0};
  localparam logic [159:0] BUSY_TXT = {"HANDLER BUSY", 64'h0};
  localparam logic [159:0] IDLE_TXT = {"HANDLER IDLE", 64'h0};

  // Configuration variable table.
  localparam int NVAR = 4;
  // Patterns list index 3 first, so variable 0 stands last in each list.
  localparam logic [3:0][159:0] VAR_NAME = '{
    {"SERIAL_NUM", 80'h0}, {"TEMP_TRIM", 88'h0},
    {"SLOT_MASK", 88'h0}, {"SCAN_MODE", 88'h0}};
  localparam logic [3:0][1:0] VAR_TYPE = '{TY_UNSIGNED, TY_SIGNED, TY_BYTES, TY_ASCII};
  localparam logic [3:0][4:0] VAR_LEN = '{5'h04, 5'h02, 5'h04, 5'h00};
  localparam logic [3:0] VAR_WR = 4'h7;
  localparam logic [3:0][127:0] VAL_RST = '{
    {32'h00000001, 96'h0}, 128'h0, 128'h0, {"AUTO", 96'h0}};

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_HDR = 5'b00010,
    ST_CODE = 5'b00100,
    ST_LEN = 5'b01000,
    ST_BODY = 5'b10000
  } mpd_st_e;

endpackage

// File: testbench/mpd_host.sv
`timescale 1ns/1ps
module mpd_host import mpd_pkg::*; (
  // Clock and answer.
  input wire logic clk_i,
  input wire logic wb_ack_i,
  // Request.
  output logic wb_cyc_o,
  output logic wb_stb_o,
  output logic wb_we_o,
  output logic [5:0] wb_adr_o,
  output logic [3:0] wb_sel_o,
  output logic [31:0] wb_dat_o
);
  logic [31:0] exp_q[$];
  int seed = 34987;
  initial {wb_cyc_o, wb_stb_o, wb_we_o, wb_adr_o, wb_sel_o, wb_dat_o} = '0;
  ////////////////////////////////////////
  // Released lines carry junk, so a slave that samples them late is caught.
  task automatic xfer(input logic we, input logic [5:0] adr, input logic [31:0] dat);
    @(posedge clk_i);
    {wb_cyc_o, wb_stb_o, wb_we_o, wb_adr_o, wb_sel_o, wb_dat_o} <= {2'h3, we, adr, 4'hF, dat};
    do @(posedge clk_i); while (wb_ack_i !== 1'b1);
    {wb_cyc_o, wb_stb_o, wb_adr_o} <= {2'h0, ~adr};
    wb_dat_o <= $random(seed);
  endtask
  task automatic wr(input logic [5:0] adr, input logic [31:0] dat);
    xfer(1'b1, adr, dat);
  endtask
  task automatic rd(input logic [5:0] adr, input logic [31:0] exp);
    exp_q.push_back(exp);
    xfer(1'b0, adr, $random(seed));
  endtask
  task automatic put(input logic [7:0] b);
    wr(ADR_DATA, {24'($random(seed)), b});
  endtask
  task automatic lcd(input logic [7:0] wl, input logic [3:0][159:0] txt);
    put(LCD_CODE);
    put(LCD_LEN);
    put(wl);
    put(8'h00);
    for (int i = 79; i >= 0; i--) put(txt[i / 20][(i % 20) * 8 +: 8]);
  endtask
  task automatic cfg(input logic [7:0] ctl, input logic [159:0] nm, input logic [127:0] v);
    put(CFG_CODE);
    put(CFG_LEN);
    put(ctl);
    put(8'h00);
    for (int i = 19; i >= 0; i--) put(nm[i * 8 +: 8]);
    put(8'h00);
    for (int i = 15; i >= 0; i--) put(v[i * 8 +: 8]);
    put(8'h00);
  endtask
endmodule // mpd_host

// File: testbench/mpd_parser_monitor.sv
`timescale 1ns/1ps
module mpd_parser_monitor import mpd_pkg::*; (
  // Bus.
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  // Results.
  input wire logic handler_busy_i,
  input wire logic [3:0] line_override_o,
  input wire logic illegal_o,
  input wire logic done_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic ctl_wr;
  logic start;
  logic fin;
  assign ctl_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0]
    && wb_adr_i == ADR_CTRL;
  assign start = ctl_wr && wb_dat_i[CTRL_START];
  assign fin = ctl_wr && wb_dat_i[CTRL_FINISH];
  ////////////////////////////////////////
  chk_ack_pulse:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  chk_ack_wait:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  chk_ack_cause:
    assert property (wb_ack_o |-> $past(wb_stb_i)) else $error("stray ack");
  chk_start_clear:
    assert property (start |=> !done_o && !illegal_o) else $error("status not cleared");
  chk_ill_sticky:
    assert property (illegal_o && !start |=> illegal_o) else $error("illegal dropped");
  chk_done_sticky:
    assert property (done_o && !start |=> done_o) else $error("done dropped");
  chk_done_cause:
    assert property ($rose(done_o) |-> $past(fin) || $past(fin, 2)) else $error("done early");
  chk_ovr_commit:
    assert property ($changed(line_override_o) |-> $past(fin) || $past(fin, 2))
      else $error("override moved");
  chk_ovr_frozen:
    assert property (illegal_o && !start |=> $stable(line_override_o))
      else $error("override after reject");
endmodule // mpd_parser_monitor
bind mpd_parser mpd_parser_monitor mpd_parser_monitor_inst (.*);

// File: testbench/testbench.sv
`timescale 1ns/1ps
module testbench import mpd_pkg::*;;
  logic clk_i;
  logic rst_i;
  logic handler_busy_i;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, illegal_o, done_o;
  logic [5:0] wb_adr_i;
  logic [3:0] wb_sel_i, line_override_o;
  logic [31:0] wb_dat_i, wb_dat_o, rv;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc_n = 0;
  logic [159:0] nms [6] = '{{"SCAN_MODE", 88'h0}, {"SLOT_MASK", 88'h0}, {"TEMP_TRIM", 88'h0},
    {"SERIAL_NUM", 80'h0}, {"SLOT_MASX", 88'h0}, 160'h0};
  logic [15:0] bad [5] = '{16'h2152, 16'h2251, 16'h3D27, 16'h3D29, 16'h2252};
  mpd_parser mpd_parser_inst (.*);
  mpd_host mpd_host_inst (.clk_i(clk_i), .wb_ack_i(wb_ack_o), .wb_cyc_o(wb_cyc_i),
    .wb_stb_o(wb_stb_i), .wb_we_o(wb_we_i), .wb_adr_o(wb_adr_i), .wb_sel_o(wb_sel_i),
    .wb_dat_o(wb_dat_i));
  ////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    if (error_cnt == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      error_cnt++;
      close_out();
    end
  end
  // Read data is taken mid-cycle, well clear of the edge that launched it.
  always @(negedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) check(wb_dat_o, mpd_host_inst.exp_q.pop_front());
  end
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    mpd_host_inst.wr(a, d);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    mpd_host_inst.rd(a, e);
  endtask
  task automatic open_list();
    wr(ADR_CTRL, 32'h1);
    repeat (4) mpd_host_inst.put(8'h00);
  endtask
  task automatic fin(input logic [31:0] st);
    wr(ADR_CTRL, 32'h2);
    rd(ADR_STAT, st);
  endtask
  task automatic dchr(input logic [1:0] l, input logic [4:0] c, input logic [7:0] e);
    wr(ADR_DADR, {25'h0, l, c});
    rd(ADR_DDAT, {24'h0, e});
  endtask
  task automatic vb(input logic [1:0] v, input logic [3:0] b, input logic [7:0] e);
    wr(ADR_VADR, {26'h0, v, b});
    rd(ADR_VDAT, {24'h0, e});
  endtask
  task automatic cf(input logic [7:0] c, input int n, input logic [31:0] v,
    input logic [31:0] st, input logic [31:0] sel);
    open_list();
    mpd_host_inst.cfg(c, nms[n], {v, 96'h0});
    fin(st);
    rd(ADR_SEL, sel);
  endtask
  ////////////////////////////////////////
  initial begin
    rst_i = 1'b1;
    handler_busy_i = 1'b0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(ADR_STAT, 32'h0);
    rd(6'h24, 32'h0);
    rd(ADR_SEL, 32'h0);
    dchr(2'h0, 5'h00, "L");
    dchr(2'h1, 5'h00, 8'h20);
    dchr(2'h2, 5'h08, "I");
    handler_busy_i <= 1'b1;
    dchr(2'h2, 5'h08, "B");
    open_list();
    mpd_host_inst.lcd(8'h05, {160'h0, {"LINE TWO", 96'h0}, 160'h0, {"HOST MSG", 96'h0}});
    fin(32'h2);
    rd(ADR_OVR, 32'hA);
    check({28'h0, line_override_o}, 32'hA);
    dchr(2'h0, 5'h00, "L");
    dchr(2'h1, 5'h01, "I");
    dchr(2'h1, 5'h08, 8'h20);
    dchr(2'h3, 5'h00, "H");
    // A bad header closes the list at once, so its FINISH is ignored and done stays low; the last, 22 52, is a good header cut off mid-page, so done rises.
    for (int i = 0; i < 5; i++) begin
      open_list();
      mpd_host_inst.put(bad[i][15:8]);
      mpd_host_inst.put(bad[i][7:0]);
      fin((i == 4) ? 32'h6 : 32'h4);
      rd(ADR_OVR, 32'hA);
    end
    open_list();
    repeat (2) mpd_host_inst.lcd(8'h0F, '0);
    fin(32'h4);
    rd(ADR_OVR, 32'hA);
    cf(8'hC2, 2, 32'hFE120000, 32'h2, 32'h2);
    vb(2'h2, 4'h1, 8'h12);
    cf(8'h24, 1, 32'hDEADBEEF, 32'h2, 32'h1);
    vb(2'h1, 4'h0, 8'h00);
    cf(8'h00, 5, 32'h0, 32'h2, 32'h0);
    cf(8'hE4, 3, 32'h2, 32'h6, 32'h0);
    cf(8'hC4, 1, 32'h0, 32'h6, 32'h0);
    cf(8'hA5, 1, 32'h0, 32'h6, 32'h0);
    cf(8'hA4, 4, 32'h0, 32'h6, 32'h0);
    cf(8'hC3, 2, 32'h0, 32'h6, 32'h0);
    vb(2'h2, 4'h0, 8'hFE);
    rv = $random(mpd_host_inst.seed);
    cf(8'hA4, 1, rv, 32'h2, 32'h1);
    vb(2'h1, 4'h3, rv[7:0]);
    cf(8'h80, 0, "MANU", 32'h2, 32'h0);
    vb(2'h0, 4'h3, "U");
    open_list();
    mpd_host_inst.cfg(8'h24, nms[1], '0);
    mpd_host_inst.lcd(8'h00, '0);
    fin(32'h2);
    rd(ADR_OVR, 32'h0);
    rd(ADR_SEL, 32'h1);
    close_out();
  end
endmodule // testbench
